/* src/rabg_regs.svh */
// register indices, field positions and reset values of the ring/bit-reverse address block
`ifndef RABG_REGS_SVH
`define RABG_REGS_SVH
// register indices on the 3-bit register port
`define RABG_IDX_XRS  3'h0
`define RABG_IDX_XRE  3'h1
`define RABG_IDX_YRS  3'h2
`define RABG_IDX_YRE  3'h3
`define RABG_IDX_CTL  3'h4
`define RABG_IDX_BRV  3'h5
`define RABG_IDX_PAGE 3'h6
`define RABG_IDX_STAT 3'h7
// reset values
`define RABG_RST16    16'h0000
`define RABG_RST8     8'h00
// ring_bitrev_control fields
`define RABG_XSEL     3:0
`define RABG_YSEL     7:4
`define RABG_BSEL     11:8
`define RABG_YEN      14
`define RABG_XEN      15
// bitrev_pivot_control fields
`define RABG_BITREV_ENABLE     15
`define RABG_PIVOT    14:0
// table page configuration-space bit
`define RABG_CFG_BIT  7
// pointer select value that means off
`define RABG_SEL_OFF  4'hf
// generator numbers: X read, X write, Y
`define RABG_GXR      0
`define RABG_GXW      1
`define RABG_GY       2
`define RABG_NGEN     3
// status bit for last X write reversed
`define RABG_STAT_BRV 3
`endif

/* src/rabg_pkg.sv */
// types shared by the ring/bit-reverse address block
package rabg_pkg;
   // addressing mode from the instruction decoder
   typedef enum logic [1:0] {
      RABG_AM_IND,    // plain register indirect
      RABG_AM_POST,   // indirect, pointer modified after use
      RABG_AM_PRE,    // indirect, pointer modified before use
      RABG_AM_OFFS    // indirect with register or literal offset
   } rabg_mode_t;

   // whole state of the top module
   typedef struct packed {
      logic [15:0]       x_ring_start;
      logic [15:0]       x_ring_end;
      logic [15:0]       y_ring_start;
      logic [15:0]       y_ring_end;
      logic [15:0]       ring_bitrev_control;
      logic [15:0]       bitrev_pivot_control;
      logic [7:0]        table_page;
      logic [3:0]        last_status;
      logic [15:0]       rdata;
      logic [2:0][15:0]  ea;
      logic [2:0]        ea_vld;
      logic [2:0][15:0]  wb;
      logic [2:0]        wb_en;
      logic [23:0]       paddr;
      logic              pvld;
      logic              pwr;
      logic              pcfg;
      logic [15:0]       psv_data;
      logic              psv_vld;
      logic              psv_flt;
   } rabg_state_t;
endpackage : rabg_pkg

/* src/rabg_ring_wrap.sv */
// circular-buffer correction of one effective address
`timescale 1ns/1ps
module rabg_ring_wrap (
   input  wire logic [15:0] addr_i,    // raw modified address
   input  wire logic [15:0] start_i,   // ring start byte address
   input  wire logic [15:0] end_i,     // ring end byte address
   input  wire logic        en_i,      // ring applies to this access
   input  wire logic        dec_i,     // step is negative
   input  wire logic        word_i,    // force word alignment
   output logic      [15:0] addr_o,    // corrected address
   output logic             wrap_o     // a correction took place
);
   logic [15:0] len;    // ring length in bytes
   logic        pow2;   // length is a power of two
   logic        over;   // above upper boundary
   logic        under;  // below lower boundary
   logic [15:0] fixed;  // corrected address before alignment

   // length only from the two bounds; a full 64 KB ring wraps to zero,
   // which is still exact in 16-bit arithmetic
   assign len   = 16'(end_i - start_i + 16'h0001);
   assign pow2  = ((len & 16'(len - 16'h0001)) == 16'h0000);

   // greater/less tests so that long steps are still caught;
   // power-of-two rings check both sides
   assign over  = (addr_i > end_i) & (~dec_i | pow2);
   assign under = (addr_i < start_i) & (dec_i | pow2);

   // subtract or add one length
   always_comb
   begin
      fixed  = addr_i;
      wrap_o = 1'b0;
      if (en_i && over)
      begin
         fixed  = 16'(addr_i - len);
         wrap_o = 1'b1;
      end
      else if (en_i && under)
      begin
         fixed  = 16'(addr_i + len);
         wrap_o = 1'b1;
      end
   end

   // word data keeps bit zero clear
   assign addr_o = {fixed[15:1], fixed[0] & ~word_i};
endmodule : rabg_ring_wrap

/* src/rabg_top.sv */
// ring and bit-reverse effective-address correction with program address forming
`timescale 1ns/1ps
`include "rabg_regs.svh"
module rabg_top (
   input  wire logic                      clk_i,         // core clock, 40 MHz
   input  wire logic                      rst_i,         // synchronous reset, high
   input  wire logic [2:0]                reg_addr_i,    // register index
   input  wire logic [15:0]               reg_wdata_i,   // register write data
   input  wire logic                      reg_wr_i,      // register write strobe
   input  wire logic                      reg_rd_i,      // register read strobe
   output logic      [15:0]               reg_rdata_o,   // read data, next cycle
   input  wire logic [2:0]                agu_req_i,     // request per generator
   input  wire logic [2:0][3:0]           agu_wnum_i,    // pointer register number
   input  wire logic [2:0][15:0]          agu_ptr_i,     // pointer value
   input  wire logic [2:0][15:0]          agu_off_i,     // signed step or offset
   input  rabg_pkg::rabg_mode_t [2:0]     agu_mode_i,    // addressing mode
   input  wire logic [2:0]                agu_byte_i,    // byte-sized access
   output logic      [2:0][15:0]          agu_ea_o,      // effective address
   output logic      [2:0]                agu_ea_vld_o,  // address valid pulse
   output logic      [2:0][15:0]          agu_wb_o,      // pointer write-back value
   output logic      [2:0]                agu_wb_en_o,   // pointer write-back pulse
   input  wire logic                      fetch_req_i,   // instruction fetch request
   input  wire logic [22:0]               pc_i,          // program counter
   output logic                           fetch_stall_o, // fetch held off by table op
   input  wire logic                      tbl_req_i,     // table read/write request
   input  wire logic                      tbl_wr_i,      // table op is a write
   input  wire logic [15:0]               tbl_ea_i,      // table effective address
   output logic      [23:0]               prog_addr_o,   // program space address
   output logic                           prog_vld_o,    // program access pulse
   output logic                           prog_wr_o,     // program access writes
   output logic                           prog_cfg_o,    // configuration space
   input  wire logic                      psv_req_i,     // data-space window access
   input  wire logic                      psv_wr_i,      // window access writes
   input  wire logic [23:0]               prog_word_i,   // program word for window
   output logic      [15:0]               psv_rdata_o,   // window read data
   output logic                           psv_vld_o,     // window read pulse
   output logic                           psv_fault_o    // window write refused
);
   import rabg_pkg::*;

   rabg_state_t st_reg;   // all state
   rabg_state_t st_next;  // next state

   logic        x_on;     // X ring configured
   logic        y_on;     // Y ring configured
   logic        brv_cfg;  // bit reversal configured
   logic [15:0] pmod;     // pivot scaled to bytes
   logic [15:0] rp;       // X write pointer, mirrored
   logic [15:0] rm;       // modifier, mirrored
   logic [15:0] rs;       // mirrored sum
   logic [15:0] brv_sum;  // reverse-carry sum
   logic [2:0][15:0] ea_c;   // per generator address
   logic [2:0][15:0] wb_c;   // per generator write-back
   logic [2:0]       wben_c; // per generator write-back enable
   logic [2:0]       wrap_c; // per generator ring correction
   logic [2:0]       brv_c;  // per generator reversal taken

   // shared enables; 15 in a select field means the feature is off
   assign x_on    = st_reg.ring_bitrev_control[`RABG_XEN]
                    & (st_reg.ring_bitrev_control[`RABG_XSEL] != `RABG_SEL_OFF);
   assign y_on    = st_reg.ring_bitrev_control[`RABG_YEN]
                    & (st_reg.ring_bitrev_control[`RABG_YSEL] != `RABG_SEL_OFF);
   assign brv_cfg = st_reg.bitrev_pivot_control[`RABG_BITREV_ENABLE]
                    & (st_reg.ring_bitrev_control[`RABG_BSEL] != `RABG_SEL_OFF);

   // pivot is in words, the address is in bytes
   assign pmod = {st_reg.bitrev_pivot_control[`RABG_PIVOT], 1'b0};

   // reverse-carry add: mirror both operands, add, mirror back
   for (genvar i = 0; i < 16; i++)
   begin : gen_mirror
      assign rp[i]      = agu_ptr_i[`RABG_GXW][15 - i];
      assign rm[i]      = pmod[15 - i];
      assign brv_sum[i] = rs[15 - i];
   end
   assign rs = 16'(rp + rm);  // carry runs toward the low address bits

   // one address path per generator
   for (genvar g = 0; g < `RABG_NGEN; g++)
   begin : gen_agu
      logic        is_y;    // Y generator
      logic        is_xw;   // X write generator
      logic [3:0]  sel;     // ring pointer select for this space
      logic        on;      // ring applies to this access
      logic        modif;   // pre or post modify mode
      logic        calc;    // mode that forms ptr + offset
      logic        brv;     // reversal taken on this access
      logic        word;    // word alignment forced
      logic [15:0] sum;     // pointer plus offset
      logic [15:0] raw;     // modified address before ring fix
      logic [15:0] fixed;   // after ring fix
      logic        wrapped; // ring fix applied
      logic [15:0] ptr_al;  // pointer with alignment forced

      assign is_y  = (g == `RABG_GY);
      assign is_xw = (g == `RABG_GXW);
      // X read and X write share the X setting
      assign sel   = is_y ? st_reg.ring_bitrev_control[`RABG_YSEL]
                          : st_reg.ring_bitrev_control[`RABG_XSEL];
      assign modif = (agu_mode_i[g] == RABG_AM_POST) | (agu_mode_i[g] == RABG_AM_PRE);
      assign calc  = modif | (agu_mode_i[g] == RABG_AM_OFFS);
      // reversal wins in the write generator only; read keeps its ring
      assign on    = (is_y ? y_on : x_on) & (agu_wnum_i[g] == sel)
                     & ~(is_xw & brv_cfg) & calc;
      // only word writes with incrementing pre/post modes are reversed
      assign brv   = is_xw & brv_cfg
                     & (agu_wnum_i[g] == st_reg.ring_bitrev_control[`RABG_BSEL])
                     & modif & ~agu_byte_i[g] & ~agu_off_i[g][15];
      assign word  = is_y | brv;
      assign sum   = 16'(agu_ptr_i[g] + agu_off_i[g]);
      // the indirect-mode offset is dropped while reversing
      assign raw   = brv ? brv_sum : sum;
      assign ptr_al = {agu_ptr_i[g][15:1], agu_ptr_i[g][0] & ~word};

      rabg_ring_wrap u_wrap (
         .addr_i  (raw),
         .start_i (is_y ? st_reg.y_ring_start : st_reg.x_ring_start),
         .end_i   (is_y ? st_reg.y_ring_end : st_reg.x_ring_end),
         .en_i    (on),
         .dec_i   (agu_off_i[g][15]),
         .word_i  (word),
         .addr_o  (fixed),
         .wrap_o  (wrapped)
      );

      // pre-modify and offset forms use the corrected address, post uses the pointer
      assign ea_c[g]   = ((agu_mode_i[g] == RABG_AM_PRE) | (agu_mode_i[g] == RABG_AM_OFFS))
                         ? fixed : ptr_al;
      assign wb_c[g]   = fixed;
      assign wben_c[g] = modif;      // offset forms never touch the pointer
      assign wrap_c[g] = wrapped;
      assign brv_c[g]  = brv;
   end

   // next-state logic: registers, address results, program access
   always_comb
   begin
      st_next          = st_reg;
      st_next.rdata    = `RABG_RST16;
      st_next.ea_vld   = 3'h0;
      st_next.wb_en    = 3'h0;
      st_next.pvld     = 1'b0;
      st_next.pwr      = 1'b0;
      st_next.psv_vld  = 1'b0;
      st_next.psv_flt  = 1'b0;

      // register writes; the status index is read-only
      if (reg_wr_i)
      begin
         case (reg_addr_i)
            `RABG_IDX_XRS:  st_next.x_ring_start         = reg_wdata_i;
            `RABG_IDX_XRE:  st_next.x_ring_end           = reg_wdata_i;
            `RABG_IDX_YRS:  st_next.y_ring_start         = reg_wdata_i;
            `RABG_IDX_YRE:  st_next.y_ring_end           = reg_wdata_i;
            `RABG_IDX_CTL:  st_next.ring_bitrev_control  = reg_wdata_i;
            `RABG_IDX_BRV:  st_next.bitrev_pivot_control = reg_wdata_i;
            `RABG_IDX_PAGE: st_next.table_page           = reg_wdata_i[7:0];
            default:        ;  // status ignores writes
         endcase
      end

      // register reads, answered in the next cycle only
      if (reg_rd_i)
      begin
         case (reg_addr_i)
            `RABG_IDX_XRS:  st_next.rdata = st_reg.x_ring_start;
            `RABG_IDX_XRE:  st_next.rdata = st_reg.x_ring_end;
            `RABG_IDX_YRS:  st_next.rdata = st_reg.y_ring_start;
            `RABG_IDX_YRE:  st_next.rdata = st_reg.y_ring_end;
            `RABG_IDX_CTL:  st_next.rdata = st_reg.ring_bitrev_control;
            `RABG_IDX_BRV:  st_next.rdata = st_reg.bitrev_pivot_control;
            `RABG_IDX_PAGE: st_next.rdata = {8'h00, st_reg.table_page};
            `RABG_IDX_STAT: st_next.rdata = {12'h000, st_reg.last_status};
            default:        st_next.rdata = `RABG_RST16;
         endcase
      end

      // address results, one cycle after each request
      for (int g = 0; g < `RABG_NGEN; g++)
      begin
         if (agu_req_i[g])
         begin
            st_next.ea[g]          = ea_c[g];
            st_next.ea_vld[g]      = 1'b1;
            st_next.wb[g]          = wb_c[g];
            st_next.wb_en[g]       = wben_c[g];
            st_next.last_status[g] = wrap_c[g];
         end
      end
      if (agu_req_i[`RABG_GXW])
      begin
         st_next.last_status[`RABG_STAT_BRV] = brv_c[`RABG_GXW];
      end

      // table ops take the program port ahead of fetch
      if (tbl_req_i)
      begin
         // no alignment forced; config pages are open to reads
         st_next.paddr = {st_reg.table_page, tbl_ea_i};
         st_next.pvld  = 1'b1;
         st_next.pwr   = tbl_wr_i;
         st_next.pcfg  = st_reg.table_page[`RABG_CFG_BIT];
      end
      else if (fetch_req_i)
      begin
         st_next.paddr = {1'b0, pc_i[22:1], 1'b0};
         st_next.pvld  = 1'b1;
         st_next.pcfg  = 1'b0;
      end

      // data-space window: reads give the low word, writes are refused
      if (psv_req_i)
      begin
         if (psv_wr_i)
         begin
            st_next.psv_flt = 1'b1;
         end
         else
         begin
            st_next.psv_data = prog_word_i[15:0];
            st_next.psv_vld  = 1'b1;
         end
      end
   end

   // state register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_reg                      <= '0;
         st_reg.x_ring_start         <= `RABG_RST16;
         st_reg.x_ring_end           <= `RABG_RST16;
         st_reg.y_ring_start         <= `RABG_RST16;
         st_reg.y_ring_end           <= `RABG_RST16;
         st_reg.ring_bitrev_control  <= `RABG_RST16;
         st_reg.bitrev_pivot_control <= `RABG_RST16;
         st_reg.table_page           <= `RABG_RST8;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // outputs straight from state
   assign reg_rdata_o   = st_reg.rdata;
   assign agu_ea_o      = st_reg.ea;
   assign agu_ea_vld_o  = st_reg.ea_vld;
   assign agu_wb_o      = st_reg.wb;
   assign agu_wb_en_o   = st_reg.wb_en;
   assign prog_addr_o   = st_reg.paddr;
   assign prog_vld_o    = st_reg.pvld;
   assign prog_wr_o     = st_reg.pwr;
   assign prog_cfg_o    = st_reg.pcfg;
   assign psv_rdata_o   = st_reg.psv_data;
   assign psv_vld_o     = st_reg.psv_vld;
   assign psv_fault_o   = st_reg.psv_flt;
   // fetch loses the port to a table op in the same cycle
   assign fetch_stall_o = fetch_req_i & tbl_req_i;

   // checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // a Y request in pre mode with the ring on
   sequence y_ring_req;
      agu_req_i[`RABG_GY] && agu_mode_i[`RABG_GY] == RABG_AM_PRE && y_on
      && agu_wnum_i[`RABG_GY] == st_reg.ring_bitrev_control[`RABG_YSEL];
   endsequence

   // a reversed X write
   sequence brv_req;
      agu_req_i[`RABG_GXW] && brv_c[`RABG_GXW];
   endsequence

   // a table op
   sequence tbl_issue;
      tbl_req_i ##0 !rst_i;
   endsequence

   y_align_a: assert property (agu_ea_vld_o[`RABG_GY] |-> !agu_ea_o[`RABG_GY][0])
      else $error("Y address not word aligned");

   x_off_a: assert property (agu_req_i[`RABG_GXR] && !x_on
      && agu_mode_i[`RABG_GXR] == RABG_AM_OFFS
      |=> agu_ea_o[`RABG_GXR]
          == 16'($past(agu_ptr_i[`RABG_GXR]) + $past(agu_off_i[`RABG_GXR])))
      else $error("X address changed with ring off");

   y_in_ring_a: assert property (y_ring_req ##0 !agu_off_i[`RABG_GY][15]
      && agu_ptr_i[`RABG_GY] >= st_reg.y_ring_start
      && agu_ptr_i[`RABG_GY] <= st_reg.y_ring_end
      && agu_off_i[`RABG_GY] <= 16'(st_reg.y_ring_end - st_reg.y_ring_start)
      |=> agu_ea_o[`RABG_GY] <= $past(st_reg.y_ring_end)
      && agu_ea_o[`RABG_GY] >= $past(st_reg.y_ring_start))
      else $error("Y ring address left the buffer");

   offs_hold_a: assert property (agu_req_i[`RABG_GXR]
      && agu_mode_i[`RABG_GXR] == RABG_AM_OFFS
      |=> agu_ea_vld_o[`RABG_GXR] && !agu_wb_en_o[`RABG_GXR])
      else $error("offset form wrote the pointer");

   post_wb_a: assert property (agu_req_i[`RABG_GY]
      && agu_mode_i[`RABG_GY] == RABG_AM_POST
      |=> agu_wb_en_o[`RABG_GY]
          && agu_ea_o[`RABG_GY] == {$past(agu_ptr_i[`RABG_GY][15:1]), 1'b0})
      else $error("post modify write-back wrong");

   brv_lsb_a: assert property (brv_req
      |=> !agu_ea_o[`RABG_GXW][0] && !agu_wb_o[`RABG_GXW][0]
      && agu_wb_o[`RABG_GXW] == {$past(brv_sum[15:1]), 1'b0})
      else $error("reversed address wrong");

   // ring is off in the write generator whenever reversal is configured
   byte_norm_a: assert property (agu_req_i[`RABG_GXW] && agu_byte_i[`RABG_GXW]
      && (!x_on || brv_cfg) && agu_mode_i[`RABG_GXW] == RABG_AM_PRE
      |=> agu_ea_o[`RABG_GXW]
          == 16'($past(agu_ptr_i[`RABG_GXW]) + $past(agu_off_i[`RABG_GXW])))
      else $error("byte write was reversed");

   fetch_addr_a: assert property (fetch_req_i && !tbl_req_i
      |=> prog_vld_o && !prog_addr_o[23] && !prog_addr_o[0] && !prog_cfg_o
      && prog_addr_o[22:1] == $past(pc_i[22:1]))
      else $error("fetch address malformed");

   tbl_addr_a: assert property (tbl_issue
      |=> prog_addr_o == {$past(st_reg.table_page), $past(tbl_ea_i)}
      && prog_cfg_o == $past(st_reg.table_page[`RABG_CFG_BIT])
      && prog_wr_o == $past(tbl_wr_i))
      else $error("table address malformed");

   psv_ro_a: assert property (psv_req_i && psv_wr_i |=> psv_fault_o && !psv_vld_o)
      else $error("window write not refused");

   rd_once_a: assert property (reg_rd_i && reg_addr_i == `RABG_IDX_STAT
      |=> reg_rdata_o[15:4] == 12'h000 ##1 reg_rdata_o == 16'h0000 || $past(reg_rd_i))
      else $error("read data stood too long");
endmodule : rabg_top

/* verif/rabg_mem_model.sv */
// program memory model that feeds the data-space window
`timescale 1ns/1ps
module rabg_mem_model (
   input  wire logic        clk_i,     // core clock
   input  wire logic        psv_req_i, // window request
   output logic      [23:0] word_o     // program word
);
   logic [23:0] junk_reg = 24'h5a5a5a; // idle filler, never a stale word
   // filler flips every cycle so an unqualified sample cannot match
   always_ff @(posedge clk_i)
      junk_reg <= ~junk_reg;
   // word present only in the request cycle
   assign word_o = psv_req_i ? 24'habcdef : junk_reg;
endmodule : rabg_mem_model

/* verif/rabg_top_tb.sv */
// self-checking bench of the ring/bit-reverse address block
`timescale 1ns/1ps
module rabg_top_tb;
   import rabg_pkg::*;
   logic clk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0;
   logic [2:0] reg_addr_i = 0, agu_req_i = 0, agu_byte_i = 0, agu_ea_vld_o, agu_wb_en_o;
   logic [15:0] reg_wdata_i = 0, tbl_ea_i = 0, reg_rdata_o, psv_rdata_o;
   logic [2:0][3:0] agu_wnum_i = 0;
   logic [2:0][15:0] agu_ptr_i = 0, agu_off_i = 0, agu_ea_o, agu_wb_o;
   rabg_mode_t [2:0] agu_mode_i;
   logic fetch_req_i = 0, tbl_req_i = 0, tbl_wr_i = 0, psv_req_i = 0, psv_wr_i = 0;
   logic [22:0] pc_i = 0;
   logic [23:0] prog_word_i, prog_addr_o;
   logic fetch_stall_o, prog_vld_o, prog_wr_o, prog_cfg_o, psv_vld_o, psv_fault_o;
   int fails = 0, total_checks = 0;
   always #12.5 clk_i = ~clk_i;
   rabg_top dut (.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
      .reg_rdata_o, .agu_req_i, .agu_wnum_i, .agu_ptr_i, .agu_off_i, .agu_mode_i,
      .agu_byte_i, .agu_ea_o, .agu_ea_vld_o, .agu_wb_o, .agu_wb_en_o, .fetch_req_i,
      .pc_i, .fetch_stall_o, .tbl_req_i, .tbl_wr_i, .tbl_ea_i, .prog_addr_o, .prog_vld_o,
      .prog_wr_o, .prog_cfg_o, .psv_req_i, .psv_wr_i, .prog_word_i, .psv_rdata_o,
      .psv_vld_o, .psv_fault_o);
   rabg_mem_model mem (.clk_i, .psv_req_i, .word_o(prog_word_i));
   // compare with four-state equality
   task automatic chk(string what, logic [23:0] seen, logic [23:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("[FAIL] %s exp %h seen %h", what, exp, seen);
      end
   endtask : chk
   // register write; strobe dropped, one idle edge before the next
   task automatic wr(logic [2:0] a, logic [15:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
      @(posedge clk_i);
   endtask : wr
   // register read, data looked at only in the cycle after the strobe
   task automatic rd(logic [2:0] a, logic [15:0] exp);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1 chk("rdata", reg_rdata_o, exp);
      @(posedge clk_i);
   endtask : rd
   // one generator request, answer one cycle later
   task automatic address_generator(int g, logic [3:0] w, logic [15:0] p, logic [15:0] o, rabg_mode_t m,
                      logic b, logic [15:0] ea, logic [15:0] wb, logic we);
      agu_wnum_i[g] <= w;
      agu_ptr_i[g] <= p;
      agu_off_i[g] <= o;
      agu_mode_i[g] <= m;
      agu_byte_i[g] <= b;
      agu_req_i[g] <= 1'b1;
      @(posedge clk_i);
      agu_req_i[g] <= 1'b0;
      #1 chk("ea_vld", agu_ea_vld_o[g], 1'b1);
      chk("ea", agu_ea_o[g], ea);
      chk("wb_en", agu_wb_en_o[g], we);
      if (we)
         chk("wb", agu_wb_o[g], wb);
      @(posedge clk_i);
   endtask : address_generator
   // program port access, fetch and table possibly together
   task automatic prog(logic f, logic t, logic w, logic [22:0] pc, logic [15:0] ea,
                       logic [23:0] exp, logic cfg);
      fetch_req_i <= f;
      tbl_req_i <= t;
      tbl_wr_i <= w;
      pc_i <= pc;
      tbl_ea_i <= ea;
      #1 chk("stall", fetch_stall_o, f & t);
      @(posedge clk_i);
      fetch_req_i <= 1'b0;
      tbl_req_i <= 1'b0;
      #1 chk("pvld", prog_vld_o, 1'b1);
      chk("paddr", prog_addr_o, exp);
      chk("pcfg", prog_cfg_o, cfg);
      chk("pwr", prog_wr_o, w);
      @(posedge clk_i);
   endtask : prog
   // data-space window access
   task automatic psv(logic w);
      psv_req_i <= 1'b1;
      psv_wr_i <= w;
      @(posedge clk_i);
      psv_req_i <= 1'b0;
      #1 chk("psv_vld", psv_vld_o, !w);
      chk("psv_fault", psv_fault_o, w);
      if (!w)
         chk("psv_data", psv_rdata_o, 16'hcdef);
      @(posedge clk_i);
   endtask : psv
   task automatic summarize;
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : summarize
   // hang guard
   initial
   begin
      repeat (4000) @(posedge clk_i);
      fails++;
      summarize();
   end
   initial
   begin
      for (int g = 0; g < 3; g++)
         agu_mode_i[g] = RABG_AM_IND;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wr(3'h2, 16'h1100);
      wr(3'h3, 16'h1163);
      wr(3'h4, 16'h4050);
      rd(3'h4, 16'h4050);
      rd(3'h3, 16'h1163);
      $display("regs done");
      address_generator(2, 5, 16'h1162, 16'h0002, RABG_AM_PRE, 0, 16'h1100, 16'h1100, 1);
      address_generator(2, 5, 16'h1162, 16'h0004, RABG_AM_OFFS, 0, 16'h1102, 0, 0);
      address_generator(2, 5, 16'h1100, 16'hfffe, RABG_AM_POST, 0, 16'h1100, 16'h1162, 1);
      address_generator(2, 5, 16'h1161, 0, RABG_AM_IND, 0, 16'h1160, 0, 0);
      $display("y ring done");
      wr(3'h0, 16'h1000);
      wr(3'h1, 16'h100f);
      wr(3'h4, 16'h8303);
      wr(3'h5, 16'h8008);
      address_generator(1, 3, 16'h2010, 16'h0002, RABG_AM_PRE, 0, 16'h2008, 16'h2008, 1);
      address_generator(1, 3, 16'h2010, 16'h0002, RABG_AM_PRE, 1, 16'h2012, 16'h2012, 1);
      address_generator(1, 3, 16'h2010, 16'h0002, RABG_AM_OFFS, 0, 16'h2012, 0, 0);
      address_generator(0, 3, 16'h100e, 16'h0004, RABG_AM_PRE, 0, 16'h1002, 16'h1002, 1);
      $display("bit reverse done");
      // status ignores writes; only the X read wrapped last
      wr(3'h7, 16'hffff);
      rd(3'h7, 16'h0001);
      wr(3'h6, 16'h0080);
      prog(1, 0, 0, 23'h7fffff, 0, 24'h7ffffe, 0);
      prog(1, 1, 0, 23'h000002, 16'h1235, 24'h801235, 1);
      wr(3'h6, 16'h0012);
      prog(0, 1, 1, 0, 16'h0035, 24'h120035, 0);
      psv(0);
      psv(1);
      $display("program port done");
      // mid-run reset clears the ring setting and the page
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(3'h4, 16'h0000);
      rd(3'h6, 16'h0000);
      address_generator(0, 3, 16'h100e, 16'h0004, RABG_AM_OFFS, 0, 16'h1012, 0, 0);
      wr(3'h4, 16'h40f0);
      address_generator(2, 15, 16'h1162, 16'h0002, RABG_AM_PRE, 0, 16'h1164, 16'h1164, 1);
      $display("reset and ring off done");
      summarize();
   end
endmodule : rabg_top_tb
